//--- hw/pt_cmd_cfg.svh
`ifndef PT_CMD_CFG_SVH
`define PT_CMD_CFG_SVH
// command codes
`define CMD_RD_MCODE 8'h45
`define CMD_WR_POS 8'hc0
`define CMD_WR_MCODE 8'hc2
`define CMD_WR_SPEED 8'hc6
`define CMD_WR_ACC 8'hc7
`define CMD_WR_DEC 8'hc8
`define CMD_WR_DWELL 8'hca
`define CMD_WR_AUX 8'hcb
// data number range
`define DNUM_MIN 8'h01
`define DNUM_MAX 8'h1f
// write mode digit values
`define WMODE_NVM_RAM 4'h0
`define WMODE_RAM 4'h1
// reply status codes
`define ST_OK 2'h0
`define ST_BAD_NUM 2'h1
`define ST_BAD_DP 2'h2
`define ST_BAD_CMD 2'h3
// field index of each table field
`define FLD_POS 3'h0
`define FLD_SPEED 3'h1
`define FLD_ACC 3'h2
`define FLD_DEC 3'h3
`define FLD_DWELL 3'h4
`define FLD_AUX 3'h5
`define FLD_MCODE 3'h6
`define NUM_FIELDS 7
`define NUM_ENTRIES 32
// flat table: eight field slots per entry, entry number above field index
`define TABLE_AW 8
`define TABLE_DEPTH 256
`endif

//--- hw/pt_cmd_pkg.sv
package pt_cmd_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [31:0] word_t;
  typedef logic [1:0] status_t;
endpackage : pt_cmd_pkg

//--- hw/pt_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pt_link_if;
  // request from master
  logic req_valid;
  pt_cmd_pkg::byte_t req_cmd;
  pt_cmd_pkg::byte_t req_num;
  pt_cmd_pkg::word_t req_data;
  logic [3:0] req_dp;
  logic [3:0] req_wmode;
  // reply from slave
  logic rsp_valid;
  pt_cmd_pkg::status_t rsp_status;
  pt_cmd_pkg::word_t rsp_data;
  modport master (output req_valid, req_cmd, req_num, req_data, req_dp, req_wmode,
    input rsp_valid, rsp_status, rsp_data);
  modport slave (input req_valid, req_cmd, req_num, req_data, req_dp, req_wmode,
    output rsp_valid, rsp_status, rsp_data);
endinterface : pt_link_if
`default_nettype wire

//--- hw/pt_table_ram.sv
`timescale 1ns/10ps
`default_nettype none
`include "pt_cmd_cfg.svh"
module pt_table_ram #(
  parameter int DEPTH = `TABLE_DEPTH,
  parameter int AW = `TABLE_AW
) (
  // clock
  input wire logic clk,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire pt_cmd_pkg::word_t wdata,
  // read port, one cycle latency
  input wire logic [AW-1:0] raddr,
  output pt_cmd_pkg::word_t rdata
);
  pt_cmd_pkg::word_t mem [DEPTH];
  // synchronous write and registered read
  always_ff @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
    rdata <= mem[raddr];
  end
endmodule : pt_table_ram
`default_nettype wire

//--- hw/pt_slave.sv
// Functional notes
// R01: read M code with 45, entry 01..1F
// R02: reply carries stored M code of entry
// R03: write position with C0, entry 01..1F
// R04: refuse position if decimal digit mismatches
// R05: mode 0 stores NVM and RAM; 1 RAM
// R06: write speed with C6
// R07: write acceleration time with C7
// R08: write deceleration time with C8
// R09: write dwell with CA
// R10: write auxiliary function with CB
// R11: write M code with C2
// R12: master prefers RAM mode for frequent writes
// R13: M code stored, no other effect
// R14: reject entry outside 01..1F, table unchanged
`timescale 1ns/10ps
`default_nettype none
`include "pt_cmd_cfg.svh"

module pt_slave (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // link to master
  pt_link_if.slave link,
  // configuration
  input wire logic [3:0] feed_multiplier_parameter,
  // non-volatile store request
  output logic nvm_wr,
  output logic [7:0] nvm_addr,
  output pt_cmd_pkg::word_t nvm_data,
  output logic [31:0] nvm_write_count
);
  typedef enum logic [1:0] {IDLE, RDWAIT, REPLY} state_t;

  // what a request asks of the table
  typedef enum logic [1:0] {CLS_READ, CLS_WRITE, CLS_OTHER} cmd_class_t;

  // the whole state; reply fields wait in pend_* until the reply goes out
  typedef struct packed {
    state_t st;
    pt_cmd_pkg::status_t pend_status;
    pt_cmd_pkg::word_t pend_data;
    logic rsp_valid;
    pt_cmd_pkg::status_t rsp_status;
    pt_cmd_pkg::word_t rsp_data;
    logic nvm_wr;
    logic [7:0] nvm_addr;
    pt_cmd_pkg::word_t nvm_data;
    logic [31:0] nvm_count;
  } regs_t;
  regs_t q_r, q_nxt;

  // table port and decode nets
  logic ram_we;
  logic [7:0] ram_waddr;
  logic [7:0] ram_raddr;
  pt_cmd_pkg::word_t ram_rdata;
  logic take;
  logic num_ok;
  logic dp_ok;
  logic store;
  logic [2:0] fld;
  logic [7:0] addr;
  cmd_class_t cls;
  pt_cmd_pkg::status_t req_status;

  // flat slot address: entry number in the upper bits, field index below
  function automatic logic [7:0] slot_addr(input pt_cmd_pkg::byte_t entry,
    input logic [2:0] field);
    slot_addr = {entry[4:0], field};
  endfunction : slot_addr

  // class and table field of the command code
  always_comb
  begin
    cls = CLS_WRITE;
    fld = `FLD_POS;
    case (link.req_cmd)
      `CMD_RD_MCODE: cls = CLS_READ; // R01
      `CMD_WR_POS: fld = `FLD_POS; // R03
      `CMD_WR_SPEED: fld = `FLD_SPEED; // R06
      `CMD_WR_ACC: fld = `FLD_ACC; // R07
      `CMD_WR_DEC: fld = `FLD_DEC; // R08
      `CMD_WR_DWELL: fld = `FLD_DWELL; // R09
      `CMD_WR_AUX: fld = `FLD_AUX; // R10
      `CMD_WR_MCODE: fld = `FLD_MCODE; // R11 R13
      default: cls = CLS_OTHER;
    endcase
  end

  // a request is taken only while idle, so one is in flight at a time
  assign take = link.req_valid && (q_r.st == IDLE);

  // entry range and decimal digit checks
  assign num_ok = (link.req_num >= `DNUM_MIN) && (link.req_num <= `DNUM_MAX); // R14
  assign dp_ok = (fld != `FLD_POS) || (link.req_dp == feed_multiplier_parameter); // R04

  // write slot of this command, and the M code slot that a read fetches
  assign addr = slot_addr(link.req_num, fld);
  assign ram_raddr = slot_addr(link.req_num, `FLD_MCODE); // R01

  // reply status of a taken request; for table commands a bad entry number wins over the rest, unknown codes get ST_BAD_CMD
  always_comb
  begin
    req_status = `ST_OK;
    store = 1'b0;
    case (cls)
      // reads check only the entry number
      CLS_READ:
      begin
        if (!num_ok)
          req_status = `ST_BAD_NUM; // R14
      end
      // writes check the number, then the decimal digit
      CLS_WRITE:
      begin
        if (!num_ok)
          req_status = `ST_BAD_NUM; // R14
        else if (!dp_ok)
          req_status = `ST_BAD_DP; // R04
        else
          store = 1'b1; // R05
      end
      // unknown codes are answered, never stored
      CLS_OTHER: req_status = `ST_BAD_CMD;
      default: req_status = `ST_BAD_CMD;
    endcase
  end

  // next state; the reply pins move only at the edge that raises rsp_valid
  always_comb
  begin
    q_nxt = q_r;
    q_nxt.rsp_valid = 1'b0;
    q_nxt.nvm_wr = 1'b0;
    ram_we = 1'b0;
    ram_waddr = addr;
    case (q_r.st)
      // wait for a request
      IDLE:
      begin
        if (take)
        begin
          q_nxt.pend_status = req_status;
          q_nxt.pend_data = '0;
          q_nxt.st = REPLY;
          // a good read waits one cycle for the table's registered read
          if (cls == CLS_READ && num_ok)
            q_nxt.st = RDWAIT; // R01
          // the RAM copy takes every stored word
          ram_we = store; // R05
          // the non-volatile copy only in mode 0; it wears, so it is counted
          if (store && link.req_wmode == `WMODE_NVM_RAM)
          begin
            q_nxt.nvm_wr = 1'b1; // R05
            q_nxt.nvm_addr = addr;
            q_nxt.nvm_data = link.req_data;
            // the wear count sticks at its top instead of wrapping to zero
            if (q_r.nvm_count != '1)
              q_nxt.nvm_count = q_r.nvm_count + 32'h1;
          end
        end
      end
      // table data is now on the read port
      RDWAIT:
      begin
        q_nxt.pend_data = ram_rdata; // R02
        q_nxt.st = REPLY;
      end
      // present the staged reply for one cycle
      REPLY:
      begin
        q_nxt.rsp_valid = 1'b1;
        q_nxt.rsp_status = q_r.pend_status;
        q_nxt.rsp_data = q_r.pend_data;
        q_nxt.st = IDLE;
      end
      // an unused encoding falls back to idle
      default: q_nxt.st = IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      q_r <= '{st: IDLE, default: '0};
    else
      q_r <= q_nxt;
  end

  // table storage, RAM copy; a slot reads unknown until first written
  pt_table_ram #(.DEPTH(`TABLE_DEPTH), .AW(`TABLE_AW)) pt_table_ram_inst (
    .clk(clk),
    .we(ram_we),
    .waddr(ram_waddr),
    .wdata(link.req_data),
    .raddr(ram_raddr),
    .rdata(ram_rdata)
  );

  // reply outputs straight from flops
  assign link.rsp_valid = q_r.rsp_valid;
  assign link.rsp_status = q_r.rsp_status;
  assign link.rsp_data = q_r.rsp_data;

  // non-volatile store request straight from flops
  assign nvm_wr = q_r.nvm_wr;
  assign nvm_addr = q_r.nvm_addr;
  assign nvm_data = q_r.nvm_data;
  assign nvm_write_count = q_r.nvm_count;
endmodule : pt_slave
`default_nettype wire

//--- hw/pt_master.sv
`timescale 1ns/10ps
`default_nettype none
`include "pt_cmd_cfg.svh"
module pt_master (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // user command
  input wire logic cmd_valid,
  input wire pt_cmd_pkg::byte_t cmd_code,
  input wire pt_cmd_pkg::byte_t cmd_num,
  input wire pt_cmd_pkg::word_t cmd_data,
  input wire logic [3:0] cmd_dp,
  input wire logic frequent_update,
  output logic cmd_ready,
  // user reply
  output logic done,
  output pt_cmd_pkg::status_t done_status,
  output pt_cmd_pkg::word_t done_data,
  // link to slave
  pt_link_if.master link
);
  typedef struct packed {
    logic busy;
    logic ready;
    logic req_valid;
    pt_cmd_pkg::byte_t cmd;
    pt_cmd_pkg::byte_t num;
    pt_cmd_pkg::word_t data;
    logic [3:0] dp;
    logic [3:0] wmode;
    logic done;
    pt_cmd_pkg::status_t st;
    pt_cmd_pkg::word_t rdata;
  } regs_t;
  regs_t q_r, q_nxt;
  // issue one request, wait for its reply
  always_comb
  begin
    q_nxt = q_r;
    q_nxt.req_valid = 1'b0;
    q_nxt.done = 1'b0;
    if (!q_r.busy && cmd_valid)
    begin
      q_nxt.busy = 1'b1;
      q_nxt.ready = 1'b0;
      q_nxt.req_valid = 1'b1; // R01 R03
      q_nxt.cmd = cmd_code;
      q_nxt.num = cmd_num;
      q_nxt.data = cmd_data;
      q_nxt.dp = cmd_dp; // R04
      q_nxt.wmode = frequent_update ? `WMODE_RAM : `WMODE_NVM_RAM; // R12
    end
    else if (q_r.busy && link.rsp_valid)
    begin
      q_nxt.busy = 1'b0;
      q_nxt.ready = 1'b1;
      q_nxt.done = 1'b1;
      q_nxt.st = link.rsp_status;
      q_nxt.rdata = link.rsp_data;
    end
  end
  // state register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      q_r <= '{ready: 1'b1, default: '0};
    else
      q_r <= q_nxt;
  end
  // outputs straight from flops
  assign cmd_ready = q_r.ready;
  assign done = q_r.done;
  assign done_status = q_r.st;
  assign done_data = q_r.rdata;
  assign link.req_valid = q_r.req_valid;
  assign link.req_cmd = q_r.cmd;
  assign link.req_num = q_r.num;
  assign link.req_data = q_r.data;
  assign link.req_dp = q_r.dp;
  assign link.req_wmode = q_r.wmode;
endmodule : pt_master
`default_nettype wire

//--- tb/pt_link_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module pt_link_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // link
  input wire logic req_valid,
  input wire logic [7:0] req_cmd,
  input wire logic [7:0] req_num,
  input wire logic rsp_valid,
  input wire logic [1:0] rsp_status,
  input wire logic [31:0] rsp_data
);
  logic ok_num;
  logic wr_cmd;
  logic tbl_cmd;
  // request classes
  assign ok_num = req_num >= 8'h01 && req_num <= 8'h1f;
  assign wr_cmd = req_cmd inside {8'hc2, 8'hc6, 8'hc7, 8'hc8, 8'hca, 8'hcb};
  assign tbl_cmd = wr_cmd || req_cmd == 8'h45 || req_cmd == 8'hc0;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_read_reply: assert property (req_valid && ok_num && req_cmd == 8'h45
    |-> ##2 !rsp_valid ##1 rsp_valid && rsp_status == 2'h0) else $error("read reply");
  a_write_ok: assert property (req_valid && ok_num && wr_cmd
    |-> ##2 rsp_valid && rsp_status == 2'h0) else $error("write status");
  a_bad_number: assert property (req_valid && !ok_num && tbl_cmd
    |-> ##2 rsp_valid && rsp_status == 2'h1) else $error("number status");
  a_bad_command: assert property (req_valid && ok_num && !wr_cmd && req_cmd != 8'h45
    && req_cmd != 8'hc0 |-> ##2 rsp_valid && rsp_status == 2'h3) else $error("cmd status");
  a_dp_outcome: assert property (req_valid && ok_num && req_cmd == 8'hc0
    |-> ##2 rsp_valid && rsp_status[0] == 1'b0) else $error("dp status");
  a_reply_pulse: assert property (rsp_valid |=> !rsp_valid) else $error("reply pulse");
  a_data_held: assert property (!rsp_valid |-> $stable(rsp_data)) else $error("data held");
  a_one_request: assert property (req_valid |=> !req_valid [*3]) else $error("overlap");
  // main scenarios
  c_read: cover property (req_valid && req_cmd == 8'h45);
  c_write: cover property (req_valid && wr_cmd);
  c_bad: cover property (rsp_valid && rsp_status == 2'h1);
endmodule : pt_link_monitor
`default_nettype wire

//--- tb/point_table_command_access_bench.sv
`timescale 1ns/10ps
`default_nettype none
module point_table_command_access_bench;
  logic clk, arst_n, cmd_valid, freq, cmd_ready, done, nvm_wr;
  logic [7:0] code, num;
  logic [31:0] data, done_data, nvm_data, nvm_total;
  logic [7:0] nvm_addr;
  logic [3:0] dp;
  logic [1:0] st;
  int num_errors = 0;
  int n_checks = 0;
  int nvm_cnt = 0;
  pt_link_if pt_link_if_inst ();
  pt_slave pt_slave_inst (.clk(clk), .arst_n(arst_n), .link(pt_link_if_inst.slave),
    .feed_multiplier_parameter(4'h1), .nvm_wr(nvm_wr), .nvm_addr(nvm_addr),
    .nvm_data(nvm_data), .nvm_write_count(nvm_total));
  pt_master pt_master_inst (.clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_code(code), .cmd_num(num), .cmd_data(data), .cmd_dp(dp), .frequent_update(freq),
    .cmd_ready(cmd_ready), .done(done), .done_status(st), .done_data(done_data),
    .link(pt_link_if_inst.master));
  pt_link_monitor pt_link_monitor_inst (.clk(clk), .arst_n(arst_n),
    .req_valid(pt_link_if_inst.req_valid), .req_cmd(pt_link_if_inst.req_cmd),
    .req_num(pt_link_if_inst.req_num), .rsp_valid(pt_link_if_inst.rsp_valid),
    .rsp_status(pt_link_if_inst.rsp_status), .rsp_data(pt_link_if_inst.rsp_data));
  // clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // counts stores to non-volatile memory
  always @(posedge clk)
    if (nvm_wr === 1'b1)
      nvm_cnt++;
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, s);
      num_errors++;
    end
  endtask : chk
  // one command through the master, then wait for its reply
  task automatic xfer(input logic [7:0] c, input logic [7:0] n, input logic [31:0] d,
    input logic [3:0] p, input logic f);
    int k;
    code = c;
    num = n;
    data = d;
    dp = p;
    freq = f;
    chk("ready", 1, cmd_ready);
    cmd_valid = 1'b1;
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    chk("busy", 0, cmd_ready);
    k = 0;
    while (done !== 1'b1)
    begin
      @(posedge clk);
      #1 k++;
      if (k > 20)
      begin
        chk("done", 1, 0);
        summarize();
      end
    end
  endtask : xfer
  task automatic t_mcode;
    xfer(8'hc2, 8'h1f, 32'h5a3c, 4'h0, 1'b1);
    chk("nvm", 0, nvm_cnt);
    xfer(8'hc2, 8'h01, 32'h1234, 4'h0, 1'b0);
    chk("nvm", 1, nvm_cnt);
    chk("nvm addr", 8'h0e, nvm_addr);
    chk("nvm data", 32'h1234, nvm_data);
    chk("nvm total", 1, nvm_total);
    xfer(8'h45, 8'h1f, 0, 4'h0, 1'b0);
    chk("mcode", 32'h5a3c, done_data);
    $display("t_mcode end");
  endtask : t_mcode
  task automatic t_fields;
    logic [7:0] cmds [5] = '{8'hc6, 8'hc7, 8'hc8, 8'hca, 8'hcb};
    int base;
    base = nvm_cnt;
    foreach (cmds[i])
    begin
      xfer(cmds[i], 8'h05, 32'h10 + i, 4'h0, 1'b0);
      chk("status", 0, st);
    end
    chk("nvm", base + 5, nvm_cnt);
    chk("nvm total", base + 5, nvm_total);
    $display("t_fields end");
  endtask : t_fields
  task automatic t_dp;
    int ok;
    ok = 0;
    for (int p = 0; p < 8; p++)
    begin
      xfer(8'hc0, 8'h02, 32'h100, p[3:0], 1'b1);
      if (st === 2'h0)
        ok++;
      else
        chk("dp status", 2, st);
    end
    chk("dp accepted", 1, ok);
    $display("t_dp end");
  endtask : t_dp
  task automatic t_bad;
    int base;
    base = nvm_cnt;
    xfer(8'hc2, 8'h00, 32'hdead, 4'h0, 1'b0);
    chk("status", 1, st);
    xfer(8'hc2, 8'h21, 32'hdead, 4'h0, 1'b0);
    chk("status", 1, st);
    chk("nvm", base, nvm_cnt);
    xfer(8'h45, 8'h01, 0, 4'h0, 1'b0);
    chk("mcode", 32'h1234, done_data);
    xfer(8'h99, 8'h01, 0, 4'h0, 1'b0);
    chk("status", 3, st);
    $display("t_bad end");
  endtask : t_bad
  // reset, then the scenarios
  initial
  begin
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    {code, num, data, dp, freq} = '0;
    repeat (4) @(posedge clk);
    #1 arst_n = 1'b1;
    t_mcode();
    t_fields();
    t_dp();
    t_bad();
    summarize();
  end
endmodule : point_table_command_access_bench
`default_nettype wire
